// ===== include/capture_timer_pkg.sv
// Constants and types for the event capture timer control block
`default_nettype none
package capture_timer_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_CTRL_A = 4'h0;
    localparam logic [3:0] OFS_CTRL_B = 4'h1;
    localparam logic [3:0] OFS_EVENT_CTRL = 4'h4;
    localparam logic [3:0] OFS_IRQ_ENABLE = 4'h5;
    localparam logic [3:0] OFS_IRQ_FLAGS = 4'h6;
    localparam logic [3:0] OFS_RUN_STATUS = 4'h7;
    localparam logic [3:0] OFS_DEBUG_BEHAVIOUR = 4'h8;
    localparam logic [3:0] OFS_WIDE_BYTE = 4'h9;
    localparam logic [3:0] OFS_COUNT_LO = 4'ha;
    localparam logic [3:0] OFS_COUNT_HI = 4'hb;
    localparam logic [3:0] OFS_COMPARE_LO = 4'hc;
    localparam logic [3:0] OFS_COMPARE_HI = 4'hd;
    // Field positions
    localparam int BIT_ENABLE = 0;
    localparam int BIT_CAPTURE_EN = 0;
    localparam int BIT_EDGE = 4;
    localparam int BIT_CAPTURE_IRQ = 0;
    localparam int BIT_RUN = 0;
    localparam int BIT_KEEP_RUNNING = 0;
    localparam int MODE_LSB = 0;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    typedef enum logic [2:0] {
        MODE_PERIODIC = 3'b000,
        MODE_TIMEOUT = 3'b001,
        MODE_CAPTURE = 3'b010,
        MODE_FREQ = 3'b011,
        MODE_PULSE = 3'b100,
        MODE_FREQ_PULSE = 3'b101,
        MODE_SINGLE = 3'b110,
        MODE_PWM8 = 3'b111
    } count_mode_t;
    typedef enum logic [1:0] {
        FP_IDLE = 2'b00,
        FP_WAIT_OPP = 2'b01,
        FP_WAIT_SECOND = 2'b10
    } fp_state_t;
endpackage
`default_nettype wire

// ===== hw/event_edge_detect.sv
// Edge detector for the incoming event line
`timescale 1ns/10ps
`default_nettype none
module event_edge_detect (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic event_in,
    input wire logic hold,
    output logic rise,
    output logic fall
);
    logic last;

    // Previous level, tracked even while held, so a held edge is lost, not replayed later
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            last <= 1'b0;
        end else begin
            last <= event_in;
        end
    end

    assign rise = event_in & ~last & ~hold;
    assign fall = ~event_in & last & ~hold;
endmodule
`default_nettype wire

// ===== hw/wide_access_byte_reg.sv
// Shared temporary byte used for 16-bit register access
`timescale 1ns/10ps
`default_nettype none
module wide_access_byte_reg (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic direct_write,
    input wire logic low_write,
    input wire logic low_read,
    input wire logic [7:0] write_data,
    input wire logic [7:0] high_byte,
    output logic [7:0] value
);
    import capture_timer_pkg::*;

    // Low write parks data; low read latches high half for the next read
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            value <= RST_BYTE;
        end else if (direct_write || low_write) begin
            value <= write_data;
        end else if (low_read) begin
            value <= high_byte;
        end
    end
endmodule
`default_nettype wire

// ===== hw/event_capture_timer_control.sv
// Event response, flag, status, debug and wide access logic of the capture timer
`timescale 1ns/10ps
`default_nettype none
module event_capture_timer_control (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [capture_timer_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic event_in,
    input wire logic debug_halt,
    output logic capture_irq,
    output logic pwm_out
);
    import capture_timer_pkg::*;

    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] event_input_control;
    logic [7:0] irq_enable;
    logic irq_flag;
    logic [7:0] debug_behaviour;
    logic [15:0] counter_value;
    logic [15:0] compare_capture_value;
    logic running;
    logic [7:0] temp_byte;
    fp_state_t fp_state;
    logic rise;
    logic fall;
    logic halted;
    logic enabled;
    logic edge_sel;
    logic sel_edge;
    logic opp_edge;
    count_mode_t mode;
    logic top_hit;
    logic pwm_hit;
    logic capture_mode;
    logic do_capture;
    logic do_restart;
    logic do_start;
    logic do_stop;
    logic set_flag;
    logic wr_lo;
    logic wr_hi;
    logic rd_lo;

    assign mode = count_mode_t'(ctrl_b[MODE_LSB +: 3]);
    assign enabled = ctrl_a[BIT_ENABLE];
    assign edge_sel = event_input_control[BIT_EDGE];
    // Debug halt only freezes us when the keep-running bit is clear
    assign halted = debug_halt & ~debug_behaviour[BIT_KEEP_RUNNING];
    assign capture_mode = (mode == MODE_CAPTURE) || (mode == MODE_FREQ) ||
                          (mode == MODE_PULSE) || (mode == MODE_FREQ_PULSE);

    event_edge_detect u_edges (
        .mclk(mclk),
        .rst_n(rst_n),
        .event_in(event_in),
        .hold(halted | ~event_input_control[BIT_CAPTURE_EN] | ~enabled),
        .rise(rise),
        .fall(fall)
    );

    // Selected edge and its opposite per edge select
    assign sel_edge = edge_sel ? fall : rise;
    assign opp_edge = edge_sel ? rise : fall;
    assign top_hit = running && (counter_value == compare_capture_value);
    assign pwm_hit = running && (counter_value[7:0] == compare_capture_value[7:0]);

    // Event decode per count mode
    always_comb begin
        do_capture = 1'b0;
        do_restart = 1'b0;
        do_start = 1'b0;
        do_stop = 1'b0;
        set_flag = 1'b0;
        unique case (mode)
            MODE_PERIODIC: set_flag = top_hit;
            MODE_PWM8: set_flag = pwm_hit;
            MODE_TIMEOUT: begin
                do_start = sel_edge;
                do_stop = opp_edge;
                set_flag = top_hit;
            end
            MODE_SINGLE: begin
                do_start = edge_sel ? (rise | fall) : rise;
                set_flag = top_hit;
            end
            MODE_CAPTURE: begin
                do_capture = sel_edge;
                set_flag = sel_edge;
            end
            MODE_FREQ: begin
                do_capture = sel_edge;
                do_restart = sel_edge;
                set_flag = sel_edge;
            end
            MODE_PULSE: begin
                do_restart = sel_edge;
                do_capture = opp_edge;
                set_flag = opp_edge;
            end
            MODE_FREQ_PULSE: begin
                do_restart = (fp_state == FP_IDLE) && sel_edge;
                do_capture = (fp_state == FP_WAIT_OPP) && opp_edge;
                do_stop = (fp_state == FP_WAIT_SECOND) && sel_edge;
                set_flag = do_stop;
            end
        endcase
    end

    // Sequencer for the combined frequency and pulse-width mode
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fp_state <= FP_IDLE;
        end else if (mode != MODE_FREQ_PULSE) begin
            fp_state <= FP_IDLE;
        end else if (do_restart) begin
            fp_state <= FP_WAIT_OPP;
        end else if (do_capture) begin
            fp_state <= FP_WAIT_SECOND;
        end else if (do_stop) begin
            fp_state <= FP_IDLE;
        end
    end

    // Running state; run bit is derived here only, never written by software
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            running <= 1'b0;
        end else if (!enabled) begin
            running <= 1'b0;
        end else if (do_stop) begin
            running <= 1'b0;
        end else if (do_start || do_restart) begin
            running <= 1'b1;
        end else if (mode == MODE_SINGLE && top_hit && !halted) begin
            running <= 1'b0; // One shot ends at top
        end else if (mode == MODE_PERIODIC || mode == MODE_CAPTURE || mode == MODE_PWM8 ||
                     mode == MODE_FREQ || mode == MODE_PULSE) begin
            running <= 1'b1;
        end
    end

    // 16-bit access strobes through the shared byte
    assign wr_lo = reg_write && (reg_addr == OFS_COUNT_LO || reg_addr == OFS_COMPARE_LO);
    assign wr_hi = reg_write && (reg_addr == OFS_COUNT_HI || reg_addr == OFS_COMPARE_HI);
    assign rd_lo = reg_read && (reg_addr == OFS_COUNT_LO || reg_addr == OFS_COMPARE_LO);

    wide_access_byte_reg u_temp (
        .mclk(mclk),
        .rst_n(rst_n),
        .direct_write(reg_write && reg_addr == OFS_WIDE_BYTE),
        .low_write(wr_lo),
        .low_read(rd_lo),
        .write_data(reg_wdata),
        .high_byte(reg_addr == OFS_COUNT_LO ? counter_value[15:8] : compare_capture_value[15:8]),
        .value(temp_byte)
    );

    // Counter; software write wins over internal updates
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            counter_value <= RST_WORD;
        end else if (wr_hi && reg_addr == OFS_COUNT_HI) begin
            counter_value <= {reg_wdata, temp_byte};
        end else if (do_restart) begin
            counter_value <= RST_WORD;
        end else if (halted || !running) begin
            counter_value <= counter_value;
        end else if ((mode == MODE_PERIODIC || mode == MODE_TIMEOUT || mode == MODE_SINGLE) && top_hit) begin
            counter_value <= RST_WORD;
        end else if (mode == MODE_PWM8 && pwm_hit) begin
            counter_value <= RST_WORD;
        end else begin
            counter_value <= counter_value + 16'h0001;
        end
    end

    // Compare/capture register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            compare_capture_value <= RST_WORD;
        end else if (wr_hi && reg_addr == OFS_COMPARE_HI) begin
            compare_capture_value <= {reg_wdata, temp_byte};
        end else if (do_capture) begin
            compare_capture_value <= counter_value;
        end
    end

    // PWM output: high while count is below the duty byte
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= (mode == MODE_PWM8) && running &&
                       (counter_value[7:0] < compare_capture_value[15:8]);
        end
    end

    // Flag: a set in the same cycle as a clear wins
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_flag <= 1'b0;
        end else if (set_flag && !halted) begin
            irq_flag <= 1'b1;
        end else if (reg_write && reg_addr == OFS_IRQ_FLAGS && reg_wdata[BIT_CAPTURE_IRQ]) begin
            irq_flag <= 1'b0;
        end else if (capture_mode && reg_read && reg_addr == OFS_COMPARE_LO) begin
            irq_flag <= 1'b0;
        end
    end

    // Plain control registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_a <= RST_BYTE;
            ctrl_b <= RST_BYTE;
            event_input_control <= RST_BYTE;
            irq_enable <= RST_BYTE;
            debug_behaviour <= RST_BYTE;
        end else if (reg_write) begin
            if (reg_addr == OFS_CTRL_A) ctrl_a <= reg_wdata;
            if (reg_addr == OFS_CTRL_B) ctrl_b <= reg_wdata;
            if (reg_addr == OFS_EVENT_CTRL) event_input_control <= reg_wdata;
            if (reg_addr == OFS_IRQ_ENABLE) irq_enable <= {7'h00, reg_wdata[BIT_CAPTURE_IRQ]};
            if (reg_addr == OFS_DEBUG_BEHAVIOUR) debug_behaviour <= {7'h00, reg_wdata[BIT_KEEP_RUNNING]};
        end
    end

    assign capture_irq = irq_enable[BIT_CAPTURE_IRQ] & irq_flag;

    // Read mux; high halves come from the shared byte
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= RST_BYTE;
        end else begin
            unique case (reg_addr)
                OFS_CTRL_A: reg_rdata <= ctrl_a;
                OFS_CTRL_B: reg_rdata <= ctrl_b;
                OFS_EVENT_CTRL: reg_rdata <= event_input_control;
                OFS_IRQ_ENABLE: reg_rdata <= irq_enable;
                OFS_IRQ_FLAGS: reg_rdata <= {7'h00, irq_flag};
                OFS_RUN_STATUS: reg_rdata <= {7'h00, running};
                OFS_DEBUG_BEHAVIOUR: reg_rdata <= debug_behaviour;
                OFS_WIDE_BYTE: reg_rdata <= temp_byte;
                OFS_COUNT_LO: reg_rdata <= counter_value[7:0];
                OFS_COMPARE_LO: reg_rdata <= compare_capture_value[7:0];
                OFS_COUNT_HI, OFS_COMPARE_HI: reg_rdata <= temp_byte;
                default: reg_rdata <= RST_BYTE;
            endcase
        end
    end

    property p_irq_gate;
        @(posedge mclk) disable iff (!rst_n)
            (set_flag && !halted && irq_enable[BIT_CAPTURE_IRQ] && !(reg_write && reg_addr == OFS_IRQ_ENABLE)) |=> capture_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq not gated by enable");

    property p_w1c;
        @(posedge mclk) disable iff (!rst_n)
            (reg_write && reg_addr == OFS_IRQ_FLAGS && reg_wdata[0] && !set_flag) |=> !irq_flag;
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag not cleared by write one");

    property p_w0_keeps;
        @(posedge mclk) disable iff (!rst_n)
            (irq_flag && reg_write && reg_addr == OFS_IRQ_FLAGS && !reg_wdata[0] && !reg_read) |=> irq_flag;
    endproperty
    a_w0_keeps: assert property (p_w0_keeps) else $error("flag lost on write zero");

    property p_read_clear;
        @(posedge mclk) disable iff (!rst_n)
            (capture_mode && reg_read && reg_addr == OFS_COMPARE_LO && !set_flag) |=> !irq_flag;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("capture read did not clear");

    property p_ignore_periodic;
        @(posedge mclk) disable iff (!rst_n)
            ((mode == MODE_PERIODIC || mode == MODE_PWM8) && !reg_write) |=> $stable(compare_capture_value);
    endproperty
    a_ignore_periodic: assert property (p_ignore_periodic) else $error("event acted in periodic");

    property p_capture_load;
        @(posedge mclk) disable iff (!rst_n)
            (mode == MODE_CAPTURE && sel_edge && !reg_write) |=> compare_capture_value == $past(counter_value) && irq_flag;
    endproperty
    a_capture_load: assert property (p_capture_load) else $error("capture not loaded");

    property p_freq_restart;
        @(posedge mclk) disable iff (!rst_n)
            (mode == MODE_FREQ && sel_edge && !reg_write) |=> counter_value == 16'h0000 && running;
    endproperty
    a_freq_restart: assert property (p_freq_restart) else $error("freq did not restart");

    property p_halt_freeze;
        @(posedge mclk) disable iff (!rst_n)
            (halted && !reg_write) |=> $stable(counter_value);
    endproperty
    a_halt_freeze: assert property (p_halt_freeze) else $error("counter moved in debug halt");

    property p_no_event_disabled;
        @(posedge mclk) disable iff (!rst_n)
            !event_input_control[0] |-> !rise && !fall;
    endproperty
    a_no_event_disabled: assert property (p_no_event_disabled) else $error("event seen while disabled");
endmodule
`default_nettype wire

// ===== testbench/event_route_model.sv
// Event line model standing in for the on-chip event routing network
`timescale 1ns/10ps
`default_nettype none
module event_route_model (
    input wire logic mclk,
    input wire logic want,
    input wire logic slow,
    output logic event_in
);
    logic stage = 1'b0;
    logic line = 1'b0;
    // Line idles low until the first request
    assign event_in = line;
    // Changes off the sampling edge; slow routing adds one cycle of delay
    always @(negedge mclk) begin
        stage <= want;
        line <= slow ? stage : want;
    end
endmodule
`default_nettype wire

// ===== testbench/event_capture_timer_control_tb.sv
// Self-checking bench for the event capture timer control block
`timescale 1ns/10ps
`default_nettype none
module event_capture_timer_control_tb;
    import capture_timer_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic event_in;
    logic debug_halt = 1'b0;
    logic capture_irq;
    logic pwm_out;
    logic want = 1'b0;
    logic slow = 1'b0;
    int n_mismatch = 0;
    int check_count = 0;
    int top;
    int hi;
    logic [7:0] rv;
    logic [15:0] r16;
    logic [15:0] c16;
    // Mode, edge select, idle level, watch run bit, expected after three toggles
    typedef struct packed {logic [2:0] mode; logic sel; logic start; logic run; logic [2:0] exp;} row_t;
    row_t rows [14] = '{'{3'd0, 1'b0, 1'b0, 1'b1, 3'b111}, '{3'd1, 1'b0, 1'b0, 1'b1, 3'b101},
        '{3'd1, 1'b1, 1'b1, 1'b1, 3'b101}, '{3'd2, 1'b0, 1'b1, 1'b0, 3'b011},
        '{3'd2, 1'b1, 1'b0, 1'b0, 3'b011}, '{3'd3, 1'b0, 1'b1, 1'b0, 3'b011},
        '{3'd3, 1'b1, 1'b0, 1'b0, 3'b011}, '{3'd4, 1'b0, 1'b0, 1'b0, 3'b011},
        '{3'd4, 1'b1, 1'b1, 1'b0, 3'b011}, '{3'd5, 1'b0, 1'b0, 1'b0, 3'b001},
        '{3'd5, 1'b1, 1'b1, 1'b0, 3'b001}, '{3'd6, 1'b0, 1'b1, 1'b1, 3'b011},
        '{3'd6, 1'b1, 1'b1, 1'b1, 3'b111}, '{3'd7, 1'b0, 1'b0, 1'b1, 3'b111}};

    event_capture_timer_control uut (
        .mclk(mclk),
        .rst_n(rst_n),
        .reg_addr(reg_addr),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .event_in(event_in),
        .debug_halt(debug_halt),
        .capture_irq(capture_irq),
        .pwm_out(pwm_out)
    );
    event_route_model partner (
        .mclk(mclk),
        .want(want),
        .slow(slow),
        .event_in(event_in)
    );

    // 25 MHz clock
    always #20 mclk = ~mclk;

    // One-cycle write strobe; a gap cycle follows so strobes never merge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge mclk);
        reg_write = 1'b0;
    endtask
    // Read data is registered, so it is settled by the next falling edge
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge mclk);
        reg_read = 1'b0;
        d = reg_rdata;
    endtask
    task automatic ck(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Event line moves only while disabled, so these edges are lost on purpose
    task automatic setup(input logic [2:0] mode, input logic sel, input logic start);
        wr(OFS_CTRL_A, 8'h00);
        wr(OFS_CTRL_B, {5'h00, mode});
        wr(OFS_EVENT_CTRL, {3'h0, sel, 4'h1});
        want <= start;
        wr(OFS_COMPARE_LO, 8'hff);
        wr(OFS_COMPARE_HI, 8'hff);
        wr(OFS_IRQ_FLAGS, 8'h01);
        wr(OFS_CTRL_A, 8'h01);
    endtask
    task automatic tog();
        @(negedge mclk);
        want <= ~want;
        repeat (4) @(negedge mclk);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Watchdog far beyond the expected thousand or so cycles
    initial begin
        #(40 * 30000);
        n_mismatch++;
        summarize();
    end

    initial begin
        void'($urandom(32'h95c1ea7e));
        repeat (20) @(negedge mclk);
        rst_n = 1'b1;
        for (int a = 5; a <= 9; a++) begin
            rd(a[3:0], rv);
            ck("reset value", RST_BYTE, rv);
        end
        rd(4'h2, rv);
        ck("unmapped", 8'h00, rv);
        wr(OFS_RUN_STATUS, 8'h01);
        rd(OFS_RUN_STATUS, rv);
        ck("run bit forced", 8'h00, rv);
        // Wide access through the shared byte, counter stopped
        r16 = 16'($urandom);
        c16 = 16'($urandom);
        wr(OFS_COUNT_LO, r16[7:0]);
        wr(OFS_COUNT_HI, r16[15:8]);
        rd(OFS_COUNT_LO, rv);
        ck("count low", r16[7:0], rv);
        rd(OFS_WIDE_BYTE, rv);
        ck("latched high", r16[15:8], rv);
        rd(OFS_COUNT_HI, rv);
        ck("count high", r16[15:8], rv);
        wr(OFS_WIDE_BYTE, c16[7:0]);
        rd(OFS_WIDE_BYTE, rv);
        ck("wide byte", c16[7:0], rv);
        wr(OFS_COUNT_HI, c16[15:8]);
        rd(OFS_COUNT_LO, rv);
        ck("count low via wide byte", c16[7:0], rv);
        // Top match in periodic mode, low byte match in PWM mode
        for (int m = 0; m < 2; m++) begin
            top = 16 + ($urandom % 32);
            wr(OFS_CTRL_A, 8'h00);
            wr(OFS_CTRL_B, m ? 8'h07 : 8'h00);
            wr(OFS_COMPARE_LO, top[7:0]);
            wr(OFS_COMPARE_HI, m ? 8'(top / 2) : 8'h00);
            wr(OFS_COUNT_LO, 8'h00);
            wr(OFS_COUNT_HI, 8'h00);
            wr(OFS_IRQ_FLAGS, 8'h01);
            wr(OFS_CTRL_A, 8'h01);
            rd(OFS_RUN_STATUS, rv);
            ck("running", 8'h01, rv);
            repeat (top / 4) @(negedge mclk);
            rd(OFS_IRQ_FLAGS, rv);
            ck("flag before match", 8'h00, rv);
            repeat (top) @(negedge mclk);
            rd(OFS_IRQ_FLAGS, rv);
            ck("flag after match", 8'h01, rv);
            // One full period of the waveform; high cycles must equal the duty byte
            hi = 0;
            repeat (top + 1) begin
                @(negedge mclk);
                if (pwm_out === 1'b1) begin
                    hi++;
                end
            end
            ck("pwm high cycles", m ? 8'(top / 2) : 8'h00, 8'(hi));
        end
        // Every mode, both edge selects for modes 1 to 6, prompt and slow event routing
        wr(OFS_IRQ_ENABLE, 8'h01);
        for (int i = 0; i < 14; i++) begin
            slow = i[0];
            setup(rows[i].mode, rows[i].sel, rows[i].start);
            for (int k = 2; k >= 0; k--) begin
                tog();
                rd(rows[i].run ? OFS_RUN_STATUS : OFS_IRQ_FLAGS, rv);
                ck("event response", {7'h00, rows[i].exp[k]}, rv);
                if (!rows[i].run) ck("irq line", {7'h00, rows[i].exp[k]}, {7'h00, capture_irq});
            end
            if (!rows[i].run) begin
                rd(OFS_COMPARE_LO, rv);
                rd(OFS_IRQ_FLAGS, rv);
                ck("flag after capture read", 8'h00, rv);
            end
        end
        // Clear by writing one only; interrupt follows its enable
        setup(3'd2, 1'b0, 1'b0);
        tog();
        wr(OFS_IRQ_FLAGS, 8'h00);
        rd(OFS_IRQ_FLAGS, rv);
        ck("flag kept", 8'h01, rv);
        wr(OFS_IRQ_ENABLE, 8'h00);
        ck("irq masked", 8'h00, {7'h00, capture_irq});
        wr(OFS_IRQ_FLAGS, 8'h01);
        rd(OFS_IRQ_FLAGS, rv);
        ck("flag cleared", 8'h00, rv);
        // Capture input disabled
        wr(OFS_EVENT_CTRL, 8'h00);
        tog();
        tog();
        rd(OFS_IRQ_FLAGS, rv);
        ck("event ignored", 8'h00, rv);
        // Debug halt with and without keep-running
        for (int d = 0; d < 2; d++) begin
            setup(3'd2, 1'b0, 1'b0);
            wr(OFS_DEBUG_BEHAVIOUR, d[7:0]);
            debug_halt = 1'b1;
            rd(OFS_COUNT_LO, r16[7:0]);
            rd(OFS_COUNT_HI, r16[15:8]);
            repeat (8) @(negedge mclk);
            rd(OFS_COUNT_LO, c16[7:0]);
            rd(OFS_COUNT_HI, c16[15:8]);
            ck("count moves", {7'h00, d[0]}, {7'h00, r16 != c16});
            tog();
            rd(OFS_IRQ_FLAGS, rv);
            ck("event during halt", {7'h00, d[0]}, rv);
            debug_halt = 1'b0;
        end
        summarize();
    end
endmodule
`default_nettype wire
